// ---- shared/bsf_pkg.sv ----
// Purpose: Constants for the bypass switch fault control block
// Assumes: 40 MHz clock
// Notes:   Times kept in their own unit, counts derived from them
package bsf_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ          = 40;
  localparam int RESTART_MS       = 100;
  localparam int RESTART_CYCLES   = RESTART_MS * 1000 * CLK_MHZ;
  localparam int OV_DEGLITCH_US   = 10;
  localparam int OV_DEGLITCH_CYC  = OV_DEGLITCH_US * CLK_MHZ;
  localparam int CNT_W            = 23;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic MASK_RESET     = 1'b1;

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    BSF_STRAP   = 3'h0,
    BSF_DELAY   = 3'h1,
    BSF_RAMP    = 3'h2,
    BSF_ACTIVE  = 3'h3,
    BSF_FAULT   = 3'h4
  } bsf_state_e;

endpackage

// ---- logic/bsf_timer.sv ----
// Purpose: Down counter with load and done flag
// Assumes: Load value nonzero
// Notes:   Done is high for one cycle when count reaches zero
`timescale 1ns/10ps
module bsf_timer
(
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Control
  input  wire logic                      load,
  input  wire logic [bsf_pkg::CNT_W-1:0] loadValue,
  input  wire logic                      run,
  // Status
  output logic                           done
);

  logic [bsf_pkg::CNT_W-1:0] count;
  logic [bsf_pkg::CNT_W-1:0] next_count;
  logic                      next_done;

  always_comb
  begin
    next_count = count;
    next_done  = 1'b0;
    if (load)
      next_count = loadValue;
    else if (run && count != {bsf_pkg::CNT_W{1'b0}})
    begin
      next_count = count - {{(bsf_pkg::CNT_W-1){1'b0}}, 1'b1};
      next_done  = (count == {{(bsf_pkg::CNT_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      done  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done  <= next_done;
    end
  end

endmodule

// ---- logic/bsf_control.sv ----
// Purpose: Mode strap, status reuse and fault restart for rail one
// Assumes: All inputs synchronous to clock; analog results as levels
// Notes:   Status read pulse clears the overcurrent latch
`timescale 1ns/10ps

// Notes on behaviour
// - In bypass the high-side switch is held on and the low side is off.
// - The passed rail turns on after its sequencing delay and ramps.
// - Power good in bypass marks ramp done with output near input.
// - Overcurrent flag in bypass follows the pass-transistor detector.
// - Unmasked bypass overcurrent drives the interrupt low and latches.
// - The overcurrent fault mask suppresses bypass overcurrent reports.
// - All four fault masks reset to one and software clears them.
// - Output comparator uses rising and falling thresholds with hysteresis.
// - Output below falling threshold raises undervoltage and shuts down.
// - After an undervoltage shutdown all rails restart after 100 ms.
// - Undervoltage fault acts only once its mask is cleared.
// - Supply above limit for 10 us turns the switch off, retry 100 ms. Here retry needs overvoltage mask and shutdown disable both clear.
// - One general-purpose pin may serve as the mode strap.
// - Strap low selects buck, strap high selects bypass.
// - A latched overcurrent stays set until its status is read.
module bsf_control
#(
  parameter int RESTART_CYCLES = bsf_pkg::RESTART_CYCLES
)
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Strap
  input  wire logic gpioIsModeStrap,
  input  wire logic modeStrap,
  // Sequencing
  input  wire logic sequenceDelayDone,
  input  wire logic softstartDone,
  // Analog comparators
  input  wire logic outAboveRising,
  input  wire logic outAboveFalling,
  input  wire logic passCurrentTrip,
  input  wire logic buckCurrentLimit,
  input  wire logic buckOutputGood,
  input  wire logic supplyOverLimit,
  // Software bits
  input  wire logic interruptUnmaskBit,
  input  wire logic maskWrite,
  input  wire logic overcurrentMaskIn,
  input  wire logic currentWarningMaskIn,
  input  wire logic overvoltageMaskIn,
  input  wire logic undervoltageMaskIn,
  input  wire logic voltageFaultShutdownDisable,
  input  wire logic statusRead,
  // Power stage
  output logic      highSideOn,
  output logic      lowSideEnable,
  output logic      softstartStart,
  output logic      allRailsShutdown,
  output logic      sequenceRelease,
  // Status
  output logic      bypassMode,
  output logic      powerGoodFlag,
  output logic      overcurrentFlag,
  output logic      overcurrentLatchFirst,
  output logic      voltageFaultState,
  output logic      interruptRequestLow,
  // Masks
  output logic      overcurrentFaultMask,
  output logic      currentWarningFaultMask,
  output logic      overvoltageFaultMask,
  output logic      undervoltageFaultMask
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  bsf_pkg::bsf_state_e state;
  bsf_pkg::bsf_state_e next_state;
  logic                next_bypassMode;
  logic                outAbove;
  logic                next_outAbove;
  logic [8:0]          ovCount;
  logic [8:0]          next_ovCount;
  logic                next_ocLatch;
  logic                next_ocMask;
  logic                next_warnMask;
  logic                next_ovMask;
  logic                next_uvMask;
  logic                timerLoad;
  logic                timerDone;
  logic                uvFault;
  logic                ovFault;
  logic                ocEvent;
  logic                railOn;
  logic                nextRailOn;

  bsf_timer u_timer
  (
    .clock     (clock),
    .rst       (rst),
    .load      (timerLoad),
    .loadValue (RESTART_CYCLES[bsf_pkg::CNT_W-1:0]),
    .run       (state == bsf_pkg::BSF_FAULT),
    .done      (timerDone)
  );

  // ------------------------------------------------------------
  // Comparators and faults
  // ------------------------------------------------------------
  always_comb
  begin
    next_outAbove = outAbove;
    if (outAboveRising)
      next_outAbove = 1'b1;
    else if (!outAboveFalling)
      next_outAbove = 1'b0;
    next_ovCount = '0;
    if (supplyOverLimit && bypassMode && railOn)
    begin
      if (ovCount == bsf_pkg::OV_DEGLITCH_CYC[8:0])
        next_ovCount = ovCount;
      else
        next_ovCount = ovCount + 9'h001;
    end
  end

  assign railOn = (state == bsf_pkg::BSF_RAMP) ||
                  (state == bsf_pkg::BSF_ACTIVE);
  assign nextRailOn = (next_state == bsf_pkg::BSF_RAMP) ||
                      (next_state == bsf_pkg::BSF_ACTIVE);
  assign uvFault = bypassMode && (state == bsf_pkg::BSF_ACTIVE) &&
                   !outAboveFalling && !undervoltageFaultMask;
  assign ovFault = (ovCount == bsf_pkg::OV_DEGLITCH_CYC[8:0]);
  assign ocEvent = bypassMode && railOn && passCurrentTrip &&
                   interruptUnmaskBit && !overcurrentFaultMask;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_bypassMode = bypassMode;
    timerLoad       = 1'b0;
    unique case (state)
      bsf_pkg::BSF_STRAP:
      begin
        // strap pin option, level picks mode, once
        next_bypassMode = gpioIsModeStrap && modeStrap;
        next_state      = bsf_pkg::BSF_DELAY;
      end
      bsf_pkg::BSF_DELAY:
        if (sequenceDelayDone)
          next_state = bsf_pkg::BSF_RAMP;
      bsf_pkg::BSF_RAMP:
        if (ovFault)
        begin
          next_state = bsf_pkg::BSF_FAULT;
          timerLoad  = 1'b1;
        end
        else if (softstartDone)
          next_state = bsf_pkg::BSF_ACTIVE;
      bsf_pkg::BSF_ACTIVE:
        if (uvFault || ovFault)
        begin
          next_state = bsf_pkg::BSF_FAULT;
          timerLoad  = 1'b1;
        end
      bsf_pkg::BSF_FAULT:
        // restart after delay, undervoltage always, overvoltage only if enabled
        if (timerDone && (voltageFaultState ||
            (!overvoltageFaultMask && !voltageFaultShutdownDisable)))
          next_state = bsf_pkg::BSF_DELAY;
    endcase
  end

  // ------------------------------------------------------------
  // Latch and masks
  // ------------------------------------------------------------
  always_comb
  begin
    next_ocLatch = overcurrentLatchFirst;
    if (statusRead)
      next_ocLatch = 1'b0;
    if (ocEvent)
      next_ocLatch = 1'b1;
    next_ocMask   = overcurrentFaultMask;
    next_warnMask = currentWarningFaultMask;
    next_ovMask   = overvoltageFaultMask;
    next_uvMask   = undervoltageFaultMask;
    if (maskWrite)
    begin
      next_ocMask   = overcurrentMaskIn;
      next_warnMask = currentWarningMaskIn;
      next_ovMask   = overvoltageMaskIn;
      next_uvMask   = undervoltageMaskIn;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state                   <= bsf_pkg::BSF_STRAP;
      bypassMode              <= 1'b0;
      outAbove                <= 1'b0;
      ovCount                 <= '0;
      overcurrentLatchFirst   <= 1'b0;
      overcurrentFaultMask    <= bsf_pkg::MASK_RESET;
      currentWarningFaultMask <= bsf_pkg::MASK_RESET;
      overvoltageFaultMask    <= bsf_pkg::MASK_RESET;
      undervoltageFaultMask   <= bsf_pkg::MASK_RESET;
      highSideOn              <= 1'b0;
      lowSideEnable           <= 1'b0;
      softstartStart          <= 1'b0;
      allRailsShutdown        <= 1'b0;
      sequenceRelease         <= 1'b0;
      powerGoodFlag           <= 1'b0;
      overcurrentFlag         <= 1'b0;
      voltageFaultState       <= 1'b0;
      interruptRequestLow     <= 1'b1;
    end
    else
    begin
      state                   <= next_state;
      bypassMode              <= next_bypassMode;
      outAbove                <= next_outAbove;
      ovCount                 <= next_ovCount;
      overcurrentLatchFirst   <= next_ocLatch;
      overcurrentFaultMask    <= next_ocMask;
      currentWarningFaultMask <= next_warnMask;
      overvoltageFaultMask    <= next_ovMask;
      undervoltageFaultMask   <= next_uvMask;
      // pass switch on while rail on, low side off in bypass
      highSideOn              <= nextRailOn;
      lowSideEnable           <= !next_bypassMode && nextRailOn;
      softstartStart          <= (state == bsf_pkg::BSF_DELAY) &&
                                 sequenceDelayDone;
      allRailsShutdown        <= (next_state == bsf_pkg::BSF_FAULT);
      // bypass: ramp done and output near input; buck: buck output good
      powerGoodFlag           <= bypassMode ?
                                 (state == bsf_pkg::BSF_ACTIVE && outAbove)
                                 : buckOutputGood;
      sequenceRelease         <= bypassMode ?
                                 (state == bsf_pkg::BSF_ACTIVE && outAbove)
                                 : buckOutputGood;
      overcurrentFlag         <= bypassMode ? passCurrentTrip
                                            : buckCurrentLimit;
      if (timerLoad)
        voltageFaultState <= uvFault;
      else if (next_state != bsf_pkg::BSF_FAULT)
        voltageFaultState <= 1'b0;
      interruptRequestLow     <= !next_ocLatch;
    end
  end

endmodule

// ---- testbench/bsf_control_sva.sv ----
// Purpose: Port checker for bsf_control
// Assumes: One clock, reset active high
// Notes:   Attached by bind below
`timescale 1ns/10ps
module bsf_control_sva
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Observed ports
  input wire logic bypassMode,
  input wire logic highSideOn,
  input wire logic lowSideEnable,
  input wire logic softstartStart,
  input wire logic sequenceRelease,
  input wire logic powerGoodFlag,
  input wire logic overcurrentFlag,
  input wire logic passCurrentTrip,
  input wire logic overcurrentLatchFirst,
  input wire logic interruptRequestLow,
  input wire logic interruptUnmaskBit,
  input wire logic overcurrentFaultMask,
  input wire logic currentWarningFaultMask,
  input wire logic overvoltageFaultMask,
  input wire logic undervoltageFaultMask,
  input wire logic maskWrite,
  input wire logic statusRead,
  input wire logic voltageFaultState,
  input wire logic allRailsShutdown
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ----
  // Sequences
  // ----
  sequence rampStart;
    softstartStart ##1 highSideOn;
  endsequence
  sequence latchRise;
    $rose(overcurrentLatchFirst);
  endsequence

  // ----
  // Assertions
  // ----
  low_side_off_a: assert property (
    bypassMode && highSideOn |-> !lowSideEnable) else $error("low side on");
  ramp_start_a: assert property (
    $rose(softstartStart) |-> rampStart) else $error("switch late");
  pgood_rel_a: assert property (
    sequenceRelease == powerGoodFlag) else $error("release differs");
  oc_follow_a: assert property (
    bypassMode && $past(bypassMode) |->
      overcurrentFlag == $past(passCurrentTrip)) else $error("flag stale");
  irq_drive_a: assert property (
    latchRise |-> !interruptRequestLow) else $error("no interrupt");
  oc_cause_a: assert property (
    latchRise |-> $past(passCurrentTrip) && $past(interruptUnmaskBit)
      && !$past(overcurrentFaultMask)) else $error("latch uncaused");
  mask_hold_a: assert property (
    !$past(maskWrite) |-> $stable({overcurrentFaultMask,
      currentWarningFaultMask, overvoltageFaultMask,
      undervoltageFaultMask})) else $error("mask moved");
  uv_shut_a: assert property (
    voltageFaultState |-> allRailsShutdown && !highSideOn)
    else $error("rails on in fault");
  uv_mask_a: assert property (
    $rose(voltageFaultState) |-> !undervoltageFaultMask)
    else $error("masked fault");
  latch_hold_a: assert property (
    $fell(overcurrentLatchFirst) |-> $past(statusRead))
    else $error("latch lost");
endmodule

bind bsf_control bsf_control_sva CHK
(
  .clock(clock), .rst(rst), .bypassMode(bypassMode),
  .highSideOn(highSideOn), .lowSideEnable(lowSideEnable),
  .softstartStart(softstartStart), .sequenceRelease(sequenceRelease),
  .powerGoodFlag(powerGoodFlag), .overcurrentFlag(overcurrentFlag),
  .passCurrentTrip(passCurrentTrip),
  .overcurrentLatchFirst(overcurrentLatchFirst),
  .interruptRequestLow(interruptRequestLow),
  .interruptUnmaskBit(interruptUnmaskBit),
  .overcurrentFaultMask(overcurrentFaultMask),
  .currentWarningFaultMask(currentWarningFaultMask),
  .overvoltageFaultMask(overvoltageFaultMask),
  .undervoltageFaultMask(undervoltageFaultMask),
  .maskWrite(maskWrite), .statusRead(statusRead),
  .voltageFaultState(voltageFaultState),
  .allRailsShutdown(allRailsShutdown)
);

// ---- testbench/bsf_host_model.sv ----
// Purpose: Host model for strap, mask writes and status reads
// Assumes: Drives off the falling clock edge
// Notes:   Mask order is overcurrent, warning, overvoltage, undervoltage
`timescale 1ns/10ps
module bsf_host_model
(
  // Clock and strap choice
  input  wire logic       clock,
  input  wire logic       strapLevel,
  // Device side
  output logic            gpioIsModeStrap,
  output logic            modeStrap,
  output logic            statusRead = 1'b0,
  output logic            maskWrite = 1'b0,
  output logic [3:0]      maskBits = 4'h0
);
  assign gpioIsModeStrap = 1'b1;
  assign modeStrap       = strapLevel;

  task automatic write_masks(input logic [3:0] m);
    @(negedge clock);
    maskWrite = 1'b1;
    maskBits  = m;
    @(negedge clock);
    maskWrite = 1'b0;
    maskBits  = ~m;
  endtask

  task automatic read_status();
    @(negedge clock);
    statusRead = 1'b1;
    @(negedge clock);
    statusRead = 1'b0;
  endtask
endmodule

// ---- testbench/bsf_control_bench.sv ----
// Purpose: Self-checking bench for bsf_control
// Assumes: Bypass strap except in test_buck, short restart count
// Notes:   Inputs change on the falling edge
`timescale 1ns/10ps
module bsf_control_bench;
  logic clock = 1'b0, rst = 1'b1, sequenceDelayDone = 1'b0;
  logic softstartDone = 1'b0, outAboveRising = 1'b0;
  logic outAboveFalling = 1'b0, passCurrentTrip = 1'b0;
  logic supplyOverLimit = 1'b0, interruptUnmaskBit = 1'b1;
  logic buckCurrentLimit = 1'b0, buckOutputGood = 1'b0;
  logic voltageFaultShutdownDisable = 1'b0, strapLevel = 1'b1;
  logic gpioIsModeStrap, modeStrap, statusRead, maskWrite;
  logic [3:0] maskBits;
  logic highSideOn, lowSideEnable, softstartStart, allRailsShutdown;
  logic sequenceRelease, bypassMode, powerGoodFlag, overcurrentFlag;
  logic overcurrentLatchFirst, voltageFaultState, interruptRequestLow;
  logic ocMask, warnMask, ovMask, uvMask;
  int   miscompares = 0, cmp_count = 0;
  wire [2:0] watch = {voltageFaultState, powerGoodFlag, highSideOn};
  wire [3:0] masks = {ocMask, warnMask, ovMask, uvMask};

  initial forever #12.5 clock = ~clock;

  bsf_host_model HOST
  (
    .clock(clock), .strapLevel(strapLevel),
    .gpioIsModeStrap(gpioIsModeStrap),
    .modeStrap(modeStrap), .statusRead(statusRead),
    .maskWrite(maskWrite), .maskBits(maskBits)
  );

  bsf_control #(.RESTART_CYCLES(20)) DUT
  (
    .clock(clock), .rst(rst), .gpioIsModeStrap(gpioIsModeStrap),
    .modeStrap(modeStrap), .sequenceDelayDone(sequenceDelayDone),
    .softstartDone(softstartDone), .outAboveRising(outAboveRising),
    .outAboveFalling(outAboveFalling), .passCurrentTrip(passCurrentTrip),
    .buckCurrentLimit(buckCurrentLimit), .buckOutputGood(buckOutputGood),
    .supplyOverLimit(supplyOverLimit),
    .interruptUnmaskBit(interruptUnmaskBit), .maskWrite(maskWrite),
    .overcurrentMaskIn(maskBits[3]), .currentWarningMaskIn(maskBits[2]),
    .overvoltageMaskIn(maskBits[1]), .undervoltageMaskIn(maskBits[0]),
    .voltageFaultShutdownDisable(voltageFaultShutdownDisable),
    .statusRead(statusRead),
    .highSideOn(highSideOn), .lowSideEnable(lowSideEnable),
    .softstartStart(softstartStart), .allRailsShutdown(allRailsShutdown),
    .sequenceRelease(sequenceRelease), .bypassMode(bypassMode),
    .powerGoodFlag(powerGoodFlag), .overcurrentFlag(overcurrentFlag),
    .overcurrentLatchFirst(overcurrentLatchFirst),
    .voltageFaultState(voltageFaultState),
    .interruptRequestLow(interruptRequestLow),
    .overcurrentFaultMask(ocMask), .currentWarningFaultMask(warnMask),
    .overvoltageFaultMask(ovMask), .undervoltageFaultMask(uvMask)
  );

  // ----
  // Helpers
  // ----
  task automatic check(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_masks(input logic [3:0] exp);
    for (int i = 0; i < 4; i++) check(masks[i], exp[i]);
  endtask
  task automatic wait_bit(input int idx, input logic val, input int lim);
    for (int n = 0; n < lim && watch[idx] !== val; n++) @(negedge clock);
    check(watch[idx], val);
    if (watch[idx] !== val) give_verdict();
  endtask
  task automatic pulse_trip();
    passCurrentTrip = 1'b1;
    @(negedge clock);
    check(overcurrentFlag, 1'b1);
    passCurrentTrip = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic ov_trip();
    supplyOverLimit = 1'b1;
    repeat (bsf_pkg::OV_DEGLITCH_CYC - 10) @(negedge clock);
    check(highSideOn, 1'b1);
    wait_bit(0, 1'b0, 20);
    supplyOverLimit = 1'b0;
  endtask
  task automatic restart(input logic strap);
    rst = 1'b1;
    strapLevel = strap;
    @(negedge clock);
    check_masks(4'hF);
    rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic test_reset();
    check_masks(4'hF);
    check(interruptRequestLow, 1'b1);
    $display("test reset done");
  endtask
  task automatic test_startup();
    repeat (3) @(negedge clock);
    check(highSideOn, 1'b0);
    sequenceDelayDone = 1'b1;
    wait_bit(0, 1'b1, 4);
    check(lowSideEnable, 1'b0);
    check(bypassMode, 1'b1);
    softstartDone = 1'b1;
    outAboveRising = 1'b1;
    outAboveFalling = 1'b1;
    wait_bit(1, 1'b1, 4);
    check(sequenceRelease, 1'b1);
    $display("test startup done");
  endtask
  task automatic test_overcurrent();
    pulse_trip();
    check(overcurrentLatchFirst, 1'b0);
    HOST.write_masks(4'h7);
    check_masks(4'h7);
    interruptUnmaskBit = 1'b0;
    pulse_trip();
    check(overcurrentLatchFirst, 1'b0);
    interruptUnmaskBit = 1'b1;
    pulse_trip();
    check(overcurrentLatchFirst, 1'b1);
    check(interruptRequestLow, 1'b0);
    HOST.read_status();
    @(negedge clock);
    check(overcurrentLatchFirst, 1'b0);
    check(interruptRequestLow, 1'b1);
    $display("test overcurrent done");
  endtask
  task automatic test_undervoltage();
    outAboveRising = 1'b0;
    repeat (3) @(negedge clock);
    check(powerGoodFlag, 1'b1);
    outAboveFalling = 1'b0;
    repeat (3) @(negedge clock);
    check(powerGoodFlag, 1'b0);
    check(voltageFaultState, 1'b0);
    HOST.write_masks(4'h6);
    wait_bit(2, 1'b1, 4);
    outAboveFalling = 1'b1;
    outAboveRising = 1'b1;
    sequenceDelayDone = 1'b0;
    softstartDone = 1'b0;
    check(allRailsShutdown, 1'b1);
    check(highSideOn, 1'b0);
    repeat (10) @(negedge clock);
    check(voltageFaultState, 1'b1);
    wait_bit(2, 1'b0, 16);
    sequenceDelayDone = 1'b1;
    wait_bit(0, 1'b1, 4);
    softstartDone = 1'b1;
    $display("test undervoltage done");
  endtask
  task automatic test_overvoltage();
    HOST.write_masks(4'h4);
    ov_trip();
    check(allRailsShutdown, 1'b1);
    wait_bit(0, 1'b1, 30);
    check(allRailsShutdown, 1'b0);
    HOST.write_masks(4'h6);
    ov_trip();
    repeat (40) @(negedge clock);
    check(highSideOn, 1'b0);
    $display("test overvoltage done");
  endtask
  task automatic test_buck();
    restart(1'b0);
    check(bypassMode, 1'b0);
    check(lowSideEnable, 1'b1);
    buckCurrentLimit = 1'b1;
    @(negedge clock);
    check(overcurrentFlag, 1'b1);
    buckCurrentLimit = 1'b0;
    buckOutputGood = 1'b1;
    @(negedge clock);
    check(powerGoodFlag, 1'b1);
    check(sequenceRelease, 1'b1);
    buckOutputGood = 1'b0;
    $display("test buck done");
  endtask
  task automatic test_shutdown_disable();
    restart(1'b1);
    check(bypassMode, 1'b1);
    HOST.write_masks(4'h4);
    voltageFaultShutdownDisable = 1'b1;
    ov_trip();
    repeat (40) @(negedge clock);
    check(highSideOn, 1'b0);
    check(allRailsShutdown, 1'b1);
    $display("test shutdown disable done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(negedge clock);
    test_reset();
    rst = 1'b0;
    test_startup();
    test_overcurrent();
    test_undervoltage();
    test_overvoltage();
    test_buck();
    test_shutdown_disable();
    give_verdict();
  end
endmodule
